// [shared/dmv_pkg.sv]
package dmv_pkg;
  // instruction word and operand fields
  localparam int INSTR_W = 14;
  localparam int PTR_W = 16;
  localparam int DATA_W = 8;
  localparam int BANK_W = 5;
  localparam int PAGE_W = 7;
  localparam int FILE_W = 7;
  localparam int BANK_LIT_MSB = 3;
  localparam int PAGE_LIT_MSB = 6;
  localparam int ACC_LIT_MSB = 7;
  localparam int FILE_ADDR_MSB = 6;
  localparam int MODE_MSB = 1;
  localparam int MODE_SEL_BIT = 2;
  localparam int REL_SEL_BIT = 6;
  localparam int REL_OFS_MSB = 5;

  // opcode masks and match values
  localparam logic [13:0] IDLE_MASK = 14'h3FFF;
  localparam logic [13:0] IDLE_MATCH = 14'h0000;
  localparam logic [13:0] BANK_MASK = 14'h3FE0;
  localparam logic [13:0] BANK_MATCH = 14'h0020;
  localparam logic [13:0] PAGE_MASK = 14'h3F80;
  localparam logic [13:0] PAGE_MATCH = 14'h3180;
  localparam logic [13:0] LIT_MASK = 14'h3F00;
  localparam logic [13:0] LIT_MATCH = 14'h3000;
  localparam logic [13:0] FILE_MASK = 14'h3F80;
  localparam logic [13:0] FILE_MATCH = 14'h0080;
  localparam logic [13:0] OPT_MASK = 14'h3FFF;
  localparam logic [13:0] OPT_MATCH = 14'h0062;
  localparam logic [13:0] STI_MASK = 14'h3FF8;
  localparam logic [13:0] STI_MATCH = 14'h0018;
  localparam logic [13:0] LDI_MASK = 14'h3FF8;
  localparam logic [13:0] LDI_MATCH = 14'h0010;
  localparam logic [13:0] REL_MASK = 14'h3F80;
  localparam logic [13:0] STIR_MATCH = 14'h3F80;
  localparam logic [13:0] LDIR_MATCH = 14'h3F00;

  // pointer update modes
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // file addresses of the two indirect data ports
  localparam logic [6:0] PORT0_ADDR = 7'h00;
  localparam logic [6:0] PORT1_ADDR = 7'h01;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] BANK_RST = 5'h00;
  localparam logic [6:0] PAGE_RST = 7'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [15:0] PTR_RST = 16'h0000;

  typedef enum logic {DMV_EXEC, DMV_LOAD_WAIT} dmv_state_t;
endpackage

// [hw/dmv_data_move.sv]
`timescale 1ns/1ns
module dmv_data_move (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // instruction stream
  input wire logic instrValid,
  input wire logic [13:0] instr,
  output logic instrReady,
  // pointer load from the rest of the core
  input wire logic ptrLoadEn,
  input wire logic ptrLoadSel,
  input wire logic [15:0] ptrLoadValue,
  // data memory
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrEn,
  output logic memRdEn,
  input wire logic [7:0] memRdData,
  // architectural state
  output logic [7:0] accumulator,
  output logic [4:0] bankSelect,
  output logic [6:0] pageLatch,
  output logic [7:0] timerOption,
  output logic [15:0] pointer0,
  output logic [15:0] pointer1,
  output logic zeroFlag
);

  dmv_pkg::dmv_state_t state_ff;
  dmv_pkg::dmv_state_t nxt_state;
  logic [7:0] acc_ff;
  logic [4:0] bank_ff;
  logic [6:0] page_ff;
  logic [7:0] option_ff;
  logic [15:0] ptr_ff [2];
  logic zero_ff;
  logic [15:0] addr_ff;
  logic [7:0] wrData_ff;
  logic wrEn_ff;
  logic rdEn_ff;

  logic accept;
  logic isIdle, isBank, isPage, isLit, isFile, isOpt;
  logic isSti, isLdi, isStiRel, isLdiRel, isPortStore;
  logic ptrSel;
  logic [1:0] mode;
  logic [15:0] relOfs;
  logic [15:0] ptrCur;
  logic [15:0] nxt_effAddr;
  logic [15:0] nxt_ptrVal;
  logic ptrUpdate;

  assign instrReady = (state_ff == dmv_pkg::DMV_EXEC);
  assign accept = instrValid && instrReady;

  // decode
  assign isIdle = (instr & dmv_pkg::IDLE_MASK) == dmv_pkg::IDLE_MATCH;
  assign isBank = (instr & dmv_pkg::BANK_MASK) == dmv_pkg::BANK_MATCH;
  assign isPage = (instr & dmv_pkg::PAGE_MASK) == dmv_pkg::PAGE_MATCH;
  assign isLit = (instr & dmv_pkg::LIT_MASK) == dmv_pkg::LIT_MATCH;
  assign isFile = (instr & dmv_pkg::FILE_MASK) == dmv_pkg::FILE_MATCH;
  assign isOpt = (instr & dmv_pkg::OPT_MASK) == dmv_pkg::OPT_MATCH;
  assign isSti = (instr & dmv_pkg::STI_MASK) == dmv_pkg::STI_MATCH;
  assign isLdi = (instr & dmv_pkg::LDI_MASK) == dmv_pkg::LDI_MATCH;
  assign isStiRel = (instr & dmv_pkg::REL_MASK) == dmv_pkg::STIR_MATCH;
  assign isLdiRel = (instr & dmv_pkg::REL_MASK) == dmv_pkg::LDIR_MATCH;
  assign isPortStore = isFile &&
    ((instr[dmv_pkg::FILE_ADDR_MSB:0] == dmv_pkg::PORT0_ADDR) ||
     (instr[dmv_pkg::FILE_ADDR_MSB:0] == dmv_pkg::PORT1_ADDR));

  assign mode = instr[dmv_pkg::MODE_MSB:0];
  assign relOfs = {{10{instr[dmv_pkg::REL_OFS_MSB]}},
    instr[dmv_pkg::REL_OFS_MSB:0]};

  always_comb begin
    if (isStiRel || isLdiRel) begin
      ptrSel = instr[dmv_pkg::REL_SEL_BIT];
    end else if (isPortStore) begin
      ptrSel = (instr[dmv_pkg::FILE_ADDR_MSB:0] == dmv_pkg::PORT1_ADDR);
    end else begin
      ptrSel = instr[dmv_pkg::MODE_SEL_BIT];
    end
  end

  assign ptrCur = ptr_ff[ptrSel];

  // effective address and pointer after the move, 16-bit wrap
  always_comb begin
    nxt_effAddr = ptrCur;
    nxt_ptrVal = ptrCur;
    ptrUpdate = 1'b0;
    if (isStiRel || isLdiRel) begin
      nxt_effAddr = ptrCur + relOfs;
    end else if (isSti || isLdi) begin
      ptrUpdate = 1'b1;
      case (mode)
        dmv_pkg::MODE_PRE_INC: begin
          nxt_ptrVal = ptrCur + 16'h0001;
          nxt_effAddr = nxt_ptrVal;
        end
        dmv_pkg::MODE_PRE_DEC: begin
          nxt_ptrVal = ptrCur - 16'h0001;
          nxt_effAddr = nxt_ptrVal;
        end
        dmv_pkg::MODE_POST_INC: begin
          nxt_ptrVal = ptrCur + 16'h0001;
        end
        dmv_pkg::MODE_POST_DEC: begin
          nxt_ptrVal = ptrCur - 16'h0001;
        end
        default: begin
          nxt_ptrVal = ptrCur;
        end
      endcase
    end
  end

  // sequencing: indirect loads wait one cycle for read data
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dmv_pkg::DMV_EXEC: begin
        if (accept && (isLdi || isLdiRel)) begin
          nxt_state = dmv_pkg::DMV_LOAD_WAIT;
        end
      end
      dmv_pkg::DMV_LOAD_WAIT: begin
        nxt_state = dmv_pkg::DMV_EXEC;
      end
      default: begin
        nxt_state = dmv_pkg::DMV_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= dmv_pkg::DMV_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // accumulator and zero flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_ff <= dmv_pkg::ACC_RST;
      zero_ff <= 1'b0;
    end else if (state_ff == dmv_pkg::DMV_LOAD_WAIT) begin
      acc_ff <= memRdData;
      zero_ff <= (memRdData == 8'h00);
    end else if (accept && isLit) begin
      acc_ff <= instr[dmv_pkg::ACC_LIT_MSB:0];
    end
  end

  // literal and option registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      bank_ff <= dmv_pkg::BANK_RST;
      page_ff <= dmv_pkg::PAGE_RST;
      option_ff <= dmv_pkg::OPTION_RST;
    end else if (accept) begin
      if (isBank) begin
        bank_ff <= {1'b0, instr[dmv_pkg::BANK_LIT_MSB:0]};
      end
      if (isPage) begin
        page_ff <= instr[dmv_pkg::PAGE_LIT_MSB:0];
      end
      if (isOpt) begin
        option_ff <= acc_ff;
      end
    end
  end

  // pointers; instruction update wins over an external load
  always_ff @(posedge mclk) begin
    if (reset) begin
      ptr_ff[0] <= dmv_pkg::PTR_RST;
      ptr_ff[1] <= dmv_pkg::PTR_RST;
    end else if (accept && ptrUpdate) begin
      ptr_ff[ptrSel] <= nxt_ptrVal;
    end else if (ptrLoadEn) begin
      ptr_ff[ptrLoadSel] <= ptrLoadValue;
    end
  end

  // memory request
  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_ff <= 16'h0000;
      wrData_ff <= 8'h00;
      wrEn_ff <= 1'b0;
      rdEn_ff <= 1'b0;
    end else begin
      wrEn_ff <= accept && (isFile || isSti || isStiRel);
      rdEn_ff <= accept && (isLdi || isLdiRel);
      if (accept && isFile && !isPortStore) begin
        addr_ff <= {4'h0, bank_ff, instr[dmv_pkg::FILE_ADDR_MSB:0]};
        wrData_ff <= acc_ff;
      end else if (accept && (isPortStore || isSti || isStiRel)) begin
        addr_ff <= nxt_effAddr;
        wrData_ff <= acc_ff;
      end else if (accept && (isLdi || isLdiRel)) begin
        addr_ff <= nxt_effAddr;
      end
    end
  end

  assign memAddr = addr_ff;
  assign memWrData = wrData_ff;
  assign memWrEn = wrEn_ff;
  assign memRdEn = rdEn_ff;
  assign accumulator = acc_ff;
  assign bankSelect = bank_ff;
  assign pageLatch = page_ff;
  assign timerOption = option_ff;
  assign pointer0 = ptr_ff[0];
  assign pointer1 = ptr_ff[1];
  assign zeroFlag = zero_ff;

  // checks
  a_bank_literal: assert property (@(posedge mclk) disable iff (reset)
    accept && isBank |=> bank_ff == {1'b0, $past(instr[3:0])})
    else $error("bank literal not loaded");
  a_bank_upper_zero: assert property (@(posedge mclk)
    disable iff (reset) accept && isBank |=> bank_ff[4] == 1'b0)
    else $error("bank literal upper bit not zero");
  a_page_literal: assert property (@(posedge mclk) disable iff (reset)
    accept && isPage |=> page_ff == $past(instr[6:0]) && $stable(zero_ff))
    else $error("page literal not loaded");
  a_acc_literal: assert property (@(posedge mclk) disable iff (reset)
    accept && isLit |=> acc_ff == $past(instr[7:0]) && instrReady)
    else $error("accumulator literal not loaded");
  a_file_store: assert property (@(posedge mclk) disable iff (reset)
    accept && isFile && !isPortStore |=> memWrEn && !memRdEn &&
      memAddr[6:0] == $past(instr[6:0]) && memWrData == $past(acc_ff))
    else $error("file store wrong");
  a_pre_inc_store: assert property (@(posedge mclk)
    disable iff (reset) accept && isSti && mode == dmv_pkg::MODE_PRE_INC
    |=> memAddr == ptr_ff[$past(ptrSel)] && memWrEn &&
      memAddr == $past(ptrCur) + 16'h0001)
    else $error("pre-increment store wrong");
  a_pre_dec_store: assert property (@(posedge mclk)
    disable iff (reset) accept && isSti && mode == dmv_pkg::MODE_PRE_DEC
    |=> memWrEn && memAddr == $past(ptrCur) - 16'h0001 &&
      ptr_ff[$past(ptrSel)] == memAddr)
    else $error("pre-decrement store wrong");
  a_post_dec_store: assert property (@(posedge mclk)
    disable iff (reset) accept && isSti && mode == dmv_pkg::MODE_POST_DEC
    |=> memAddr == $past(ptrCur) &&
      ptr_ff[$past(ptrSel)] == $past(ptrCur) - 16'h0001)
    else $error("post-decrement store wrong");
  a_rel_store: assert property (@(posedge mclk) disable iff (reset)
    accept && isStiRel && !ptrLoadEn |=>
      memAddr == $past(ptrCur) + $past(relOfs) &&
      ptr_ff[$past(ptrSel)] == $past(ptrCur))
    else $error("relative store wrong");
  a_port_redirect: assert property (@(posedge mclk)
    disable iff (reset) accept && isPortStore |=> memWrEn &&
      memAddr == $past(ptrCur))
    else $error("indirect port not redirected");
  a_ptr_wrap: assert property (@(posedge mclk) disable iff (reset)
    accept && isSti && mode == 2'h2 && ptrCur == 16'hFFFF |=>
      ptr_ff[$past(ptrSel)] == 16'h0000)
    else $error("pointer did not wrap");
  a_ptr_load: assert property (@(posedge mclk)
    disable iff (reset) ptrLoadEn && !(accept && ptrUpdate) |=>
      ptr_ff[$past(ptrLoadSel)] == $past(ptrLoadValue))
    else $error("external pointer load lost");
  a_status_hold: assert property (@(posedge mclk) disable iff (reset)
    accept && !isLdi && !isLdiRel |=> $stable(zero_ff))
    else $error("status changed by non-load");
  a_option_load: assert property (@(posedge mclk) disable iff (reset)
    accept && isOpt |=> option_ff == $past(acc_ff))
    else $error("option not loaded");
  a_load_zero: assert property (@(posedge mclk) disable iff (reset)
    accept && (isLdi || isLdiRel) |=> memRdEn && !instrReady ##1
      acc_ff == $past(memRdData) && zero_ff == ($past(memRdData) == 8'h00))
    else $error("indirect load wrong");
  a_idle_nochange: assert property (@(posedge mclk)
    disable iff (reset) accept && isIdle && !ptrLoadEn |=>
      $stable(acc_ff) && $stable(zero_ff) && $stable(ptr_ff[0]) &&
      $stable(ptr_ff[1]) && !memWrEn && instrReady)
    else $error("idle changed state");

  c_rel_store: cover property (@(posedge mclk) disable iff (reset)
    accept && isStiRel && relOfs[15]);
  c_load_zero: cover property (@(posedge mclk) disable iff (reset)
    memRdEn ##1 zero_ff);
  c_port_store: cover property (@(posedge mclk) disable iff (reset)
    accept && isPortStore);
  c_load_wrap: cover property (@(posedge mclk) disable iff (reset)
    accept && isLdi && mode[0] && ptrCur == 16'h0000);
endmodule

// [bench/dmv_data_move_test.sv]
`timescale 1ns/1ns
module dmv_data_move_test;
  typedef struct {
    logic [7:0] a, o, d;
    logic [4:0] b;
    logic [6:0] pg;
    logic [15:0] p0, p1, ad;
    logic z, wr, rd;
  } dmv_note_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic instrValid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic ptrLoadEn = 1'b0;
  logic ptrLoadSel = 1'b0;
  logic [15:0] ptrLoadValue = 16'h0000;
  logic [7:0] memRdData = 8'h00;
  logic instrReady, memWrEn, memRdEn, zeroFlag;
  logic [15:0] memAddr, pointer0, pointer1;
  logic [7:0] memWrData, accumulator, timerOption, rdv;
  logic [4:0] bankSelect;
  logic [6:0] pageLatch;
  logic took = 1'b0;
  dmv_note_t q[$];
  dmv_note_t m, e;
  int seed = 32'hECA8;
  int n_mismatch = 0;
  int n_checks = 0;

  always #5 mclk = ~mclk;

  dmv_data_move dmv_data_move_i (.mclk, .reset, .instrValid, .instr,
    .instrReady, .ptrLoadEn, .ptrLoadSel, .ptrLoadValue, .memAddr,
    .memWrData, .memWrEn, .memRdEn, .memRdData, .accumulator, .bankSelect,
    .pageLatch, .timerOption, .pointer0, .pointer1, .zeroFlag);

  task tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic ok, input string s);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask

  function automatic logic hit(logic [13:0] w, logic [13:0] mk,
                               logic [13:0] mt);
    return (w & mk) == mt;
  endfunction

  // model one instruction, note the result, then present it
  task automatic issue(input logic [13:0] w, input logic pe = 1'b0,
      input logic ps = 1'b0, input logic [15:0] pv = 16'h0000);
    logic [15:0] p, ea;
    logic upd;
    m.wr = 1'b0;
    m.rd = 1'b0;
    upd = 1'b0;
    if (hit(w, dmv_pkg::BANK_MASK, dmv_pkg::BANK_MATCH)) begin
      m.b = {1'b0, w[3:0]};
    end else if (hit(w, dmv_pkg::PAGE_MASK, dmv_pkg::PAGE_MATCH)) begin
      m.pg = w[6:0];
    end else if (hit(w, dmv_pkg::LIT_MASK, dmv_pkg::LIT_MATCH)) begin
      m.a = w[7:0];
    end else if (hit(w, dmv_pkg::OPT_MASK, dmv_pkg::OPT_MATCH)) begin
      m.o = m.a;
    end else if (hit(w, dmv_pkg::FILE_MASK, dmv_pkg::FILE_MATCH)) begin
      m.wr = 1'b1;
      m.d = m.a;
      if (w[6:1] == 6'h00) m.ad = w[0] ? m.p1 : m.p0;
      else m.ad = {4'h0, m.b, w[6:0]};
    end else if (hit(w, dmv_pkg::STI_MASK, dmv_pkg::STI_MATCH) ||
                 hit(w, dmv_pkg::LDI_MASK, dmv_pkg::LDI_MATCH)) begin
      upd = 1'b1;
      p = w[2] ? m.p1 : m.p0;
      ea = w[0] ? p - 16'h0001 : p + 16'h0001;
      m.ad = w[1] ? p : ea;
      if (w[2]) m.p1 = ea;
      else m.p0 = ea;
      m.rd = !w[3];
      m.wr = w[3];
      m.d = m.a;
    end else if (hit(w, dmv_pkg::REL_MASK, dmv_pkg::STIR_MATCH) ||
                 hit(w, dmv_pkg::REL_MASK, dmv_pkg::LDIR_MATCH)) begin
      p = w[6] ? m.p1 : m.p0;
      m.ad = p + {{10{w[5]}}, w[5:0]};
      m.rd = !w[7];
      m.wr = w[7];
      m.d = m.a;
    end
    if (m.rd) begin
      m.a = rdv;
      m.z = (rdv == 8'h00);
    end
    if (pe && !upd) begin
      if (ps) m.p1 = pv;
      else m.p0 = pv;
    end
    q.push_back(m);
    instr = w;
    instrValid = 1'b1;
    memRdData = rdv;
    ptrLoadEn = pe;
    ptrLoadSel = ps;
    ptrLoadValue = pv;
    @(posedge mclk);
    #1;
    if (m.rd) begin
      instrValid = 1'b0;
      ptrLoadEn = 1'b0;
      @(posedge mclk);
      #1;
    end
  endtask

  always @(posedge mclk) took <= instrValid && instrReady && !reset;

  always @(posedge mclk) begin
    #2;
    if (took) begin
      e = q.pop_front();
      chk(bankSelect === e.b && pageLatch === e.pg, "bank/page");
      chk(timerOption === e.o, "option");
      chk(pointer0 === e.p0 && pointer1 === e.p1, "pointer");
      chk(memWrEn === e.wr && memRdEn === e.rd, "strobe");
      if (e.wr || e.rd) chk(memAddr === e.ad, "address");
      if (e.wr) chk(memWrData === e.d, "write data");
      if (e.rd) begin
        chk(instrReady === 1'b0, "bubble");
        @(posedge mclk);
        #2;
      end
      chk(accumulator === e.a && zeroFlag === e.z, "acc/zero");
    end
  end

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    m.a = dmv_pkg::ACC_RST;
    m.o = dmv_pkg::OPTION_RST;
    m.b = dmv_pkg::BANK_RST;
    m.pg = dmv_pkg::PAGE_RST;
    m.p0 = dmv_pkg::PTR_RST;
    m.p1 = dmv_pkg::PTR_RST;
    m.z = 1'b0;
    m.d = 8'h00;
    m.ad = 16'h0000;
    rdv = 8'h00;
    repeat (20) @(posedge mclk);
    #1;
    reset = 1'b0;
    issue(14'h0000);
    issue(14'h003F);
    issue(14'h31FF);
    issue(14'h3180);
    issue(14'h30FF);
    issue(14'h305A);
    issue(14'h0062);
    issue(14'h0000, 1'b1, 1'b0, 16'h1234);
    issue(14'h002A, 1'b1, 1'b1, 16'h00C0);
    for (int i = 0; i < 6; i++) begin
      issue(14'h0080 | (i < 2 ? 14'(i) :
        14'($random(seed)) & 14'h007F));
    end
    issue(14'h00FF);
    for (int i = 0; i < 16; i++) begin
      rdv = i[1] ? 8'h00 : 8'($random(seed));
      issue(14'h0000, 1'b1, i[2], i[0] ? 16'h0000 : 16'hFFFF);
      issue((i[3] ? 14'h0010 : 14'h0018) | 14'(i[2:0]));
    end
    for (int i = 0; i < 8; i++) begin
      rdv = 8'($random(seed));
      issue({6'h3F, i[2], i[1], i[0] ? 6'h1F : 6'h20});
    end
    issue(14'h0000, 1'b1, 1'b0, 16'h4321);
    issue(14'h0018, 1'b1, 1'b0, 16'hBEEF);
    issue(14'h0000);
    repeat (80) begin
      rdv = 8'($random(seed));
      issue(14'($random(seed)));
    end
    instrValid = 1'b0;
    ptrLoadEn = 1'b0;
    repeat (3) @(posedge mclk);
    chk(q.size() == 0, "instruction never taken");
    tally_and_finish();
  end
endmodule
